// *** rtl/dimrc_ctrl.v ***
// Purpose: mode decode of contact and analog inputs, and start/stop ramp control
// Assumes: all inputs synchronous to core_clk; analog inputs 12-bit codes
// Notes:   frequency in 0.1 Hz units; ramp times in whole seconds
//
// Behaviour
// - config 4, second contact open: primary, setpoint one
// - config 4, second contact closed: secondary, setpoint two
// - config 4: run/stop contact is run command
// - config 5: speed from 0-5 V input
// - voltage speed ignored below floor frequency
// - floor default 30 Hz, minimum 5 Hz
// - configs 5, 6 need both contacts closed
// - config 6: linear speed from current, no regulation
// - current speed ignored below floor frequency
// - config 7: run/stop contact gates running
// - config 7: mode contact open pressure, closed pot
// - config 7: second contact needed only in pressure
// - pre-charge, lead/lag only in pressure configs
// - decel ramp time spans floor to maximum frequency
// - start ramp defaults 8 s, adjustable
// - default freewheel stop, no decel ramp
// - well protection: below 30 Hz one second max, unless the target is below 30 Hz
// - well protection: 1 s to the higher of floor and 30 Hz, total the start ramp time if over 1 s
// - no well protection: linear 0 to max over ramp
// - config 0 runs with both contacts closed
`timescale 1ns/1ps
`include "dimrc_defines.vh"

module dimrc_ctrl (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // contact inputs, high = closed
    input  wire        run_stop_contact,
    input  wire        second_contact_input,
    input  wire        mode_select_contact,
    // analog inputs, 12-bit codes
    input  wire [11:0] primary_loop_input,
    input  wire [11:0] secondary_loop_input,
    input  wire [11:0] volt_input,
    // parameters, sampled when param_load is high, except reg_unit_in which is registered every cycle
    input  wire        param_load,
    input  wire [3:0]  cfg_in,
    input  wire [15:0] floor_freq_in,
    input  wire [15:0] max_freq_in,
    input  wire [7:0]  up_ramp_s_in,
    input  wire [7:0]  dn_ramp_s_in,
    input  wire        well_protect_in,
    input  wire        freewheel_stop_option,
    input  wire [1:0]  reg_unit_in,
    // pressure regulator result
    input  wire [15:0] pressure_freq,
    // outputs
    output reg         run_ff,
    output reg         pressure_mode_ff,
    output reg         sensor_sel_ff,
    output reg         setpoint_sel_ff,
    output reg  [1:0]  reg_unit_ff,
    output reg         precharge_en_ff,
    output reg         leadlag_en_ff,
    output reg  [15:0] freq_ref_ff
);

    // ------------------------------------------------------------------------
    // parameter store
    // ------------------------------------------------------------------------
    reg [3:0]  cfg_ff;
    reg [15:0] floor_ff;
    reg [15:0] fmax_ff;
    reg [7:0]  up_s_ff;
    reg [7:0]  dn_s_ff;
    reg        well_ff;
    reg        coast_ff;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff   <= `DIMRC_CFG_BASIC;
            floor_ff <= `DIMRC_FMIN_RST;
            fmax_ff  <= `DIMRC_FMAX_RST;
            up_s_ff  <= `DIMRC_UP_RAMP_RST;
            dn_s_ff  <= `DIMRC_DN_RAMP_RST;
            well_ff  <= `DIMRC_WELL_RST;
            coast_ff <= `DIMRC_COAST_RST;
        end else if (param_load) begin
            cfg_ff   <= cfg_in;
            // floor clamped to 5 Hz minimum
            floor_ff <= (floor_freq_in < `DIMRC_FMIN_LOW) ? `DIMRC_FMIN_LOW
                                                           : floor_freq_in;
            fmax_ff  <= max_freq_in;
            up_s_ff  <= (up_ramp_s_in == 8'h00) ? 8'h01 : up_ramp_s_in;
            dn_s_ff  <= (dn_ramp_s_in == 8'h00) ? 8'h01 : dn_ramp_s_in;
            well_ff  <= well_protect_in;
            coast_ff <= freewheel_stop_option;
        end
    end

    // ------------------------------------------------------------------------
    // analog to frequency scaling
    // ------------------------------------------------------------------------
    function [15:0] scale_freq;
        input [11:0] code;
        input [11:0] zero;
        input [15:0] fmax;
        reg   [11:0] span;
        reg   [11:0] off;
        reg   [27:0] prod;
        reg   [27:0] quo;
        begin
            span = `DIMRC_ADC_FULL - zero;
            off  = (code > zero) ? code - zero : 12'h000;
            prod = {16'h0000, off} * {12'h000, fmax};
            quo  = (span == 12'h000) ? 28'h000_0000 : prod / {16'h0000, span};
            scale_freq = quo[15:0];
        end
    endfunction

    wire [15:0] volt_freq = scale_freq(volt_input, 12'h000, fmax_ff);
    wire [15:0] curr_freq = scale_freq(primary_loop_input, `DIMRC_ADC_4MA, fmax_ff);

    // ------------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------------
    function is_pressure_cfg;
        input [3:0] c;
        begin
            is_pressure_cfg = (c == `DIMRC_CFG_DCP) || (c == `DIMRC_CFG_ACP) ||
                              (c == `DIMRC_CFG_RED) || (c == `DIMRC_CFG_DUAL) ||
                              (c == `DIMRC_CFG_HANDAUTO);
        end
    endfunction

    reg        run_req;
    reg        pmode;
    reg        ssel;
    reg        spsel;
    reg [15:0] tgt;
    reg        speed_mode;
    reg [15:0] speed_freq;

    always @* begin
        run_req    = 1'b0;
        pmode      = 1'b0;
        ssel       = 1'b0;
        spsel      = 1'b0;
        speed_mode = 1'b0;
        speed_freq = 16'h0000;
        case (cfg_ff)
            `DIMRC_CFG_BASIC: begin
                run_req = run_stop_contact && second_contact_input;
            end
            `DIMRC_CFG_DUAL: begin
                run_req = run_stop_contact;
                pmode   = 1'b1;
                ssel    = second_contact_input;
                spsel   = second_contact_input;
            end
            `DIMRC_CFG_VSPD: begin
                run_req    = run_stop_contact && second_contact_input;
                speed_mode = 1'b1;
                speed_freq = volt_freq;
            end
            `DIMRC_CFG_ISPD: begin
                run_req    = run_stop_contact && second_contact_input;
                speed_mode = 1'b1;
                speed_freq = curr_freq;
            end
            `DIMRC_CFG_HANDAUTO: begin
                if (mode_select_contact) begin
                    run_req    = run_stop_contact;
                    speed_mode = 1'b1;
                    speed_freq = volt_freq;
                end else begin
                    run_req = run_stop_contact && second_contact_input;
                    pmode   = 1'b1;
                end
            end
            default: begin
                run_req = run_stop_contact && second_contact_input;
                pmode   = is_pressure_cfg(cfg_ff);
            end
        endcase
        // ignore analog speed until it reaches the floor
        if (speed_mode && speed_freq < floor_ff) begin
            run_req = 1'b0;
        end
        if (!run_req) begin
            tgt = 16'h0000;
        end else if (pmode) begin
            tgt = (pressure_freq < floor_ff) ? floor_ff : pressure_freq;
        end else if (speed_mode) begin
            tgt = (speed_freq > fmax_ff) ? fmax_ff : speed_freq;
        end else begin
            tgt = fmax_ff;
        end
    end

    // ------------------------------------------------------------------------
    // timebase and step sizes
    // ------------------------------------------------------------------------
    localparam [13:0] TICK_LAST = `DIMRC_TICK_LAST;
    localparam [15:0] TPS       = `DIMRC_TPS_W;
    localparam [15:0] WELL_T    = `DIMRC_WELL_TICKS_W;

    reg [13:0] div_ff;
    reg        tick_ff;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_ff  <= 14'h0000;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (div_ff == TICK_LAST);
            div_ff  <= (div_ff == TICK_LAST) ? 14'h0000 : div_ff + 14'h0001;
        end
    end

    // well mode must clear 30 Hz within the first second, whatever the floor
    reg [15:0] lo_top;
    reg [15:0] span_hi;
    reg [15:0] span_well;

    always @* begin
        lo_top = `DIMRC_WELL_FREQ;
        if (floor_ff > `DIMRC_WELL_FREQ) begin
            lo_top = floor_ff;
        end
        span_hi = 16'h0000;
        if (fmax_ff > floor_ff) begin
            span_hi = fmax_ff - floor_ff;
        end
        span_well = 16'h0000;
        if (fmax_ff > lo_top) begin
            span_well = fmax_ff - lo_top;
        end
    end

    // well mode splits the start time: 1 s to the low top, rest to maximum
    wire [7:0]  hi_s     = (well_ff && up_s_ff > 8'h01) ? up_s_ff - 8'h01 : up_s_ff;
    wire [23:0] hi_ticks = {16'h0000, hi_s} * {8'h00, TPS};
    wire [23:0] dn_ticks = {16'h0000, dn_s_ff} * {8'h00, TPS};
    wire [23:0] lo_ticks = {8'h00, WELL_T};

    wire [15:0] ramp_freq;

    // remainder carried across ticks so slow ramps keep their full time
    reg [23:0] acc_ff;
    reg [23:0] span_sel;
    reg [23:0] ticks_sel;
    reg [23:0] acc_sum;
    reg [23:0] step_q;
    reg [23:0] nxt_acc;

    always @* begin
        span_sel  = {8'h00, span_hi};
        ticks_sel = dn_ticks;
        if (ramp_freq < tgt) begin
            if (well_ff && ramp_freq < lo_top) begin
                span_sel  = {8'h00, lo_top};
                ticks_sel = lo_ticks;
            end else if (well_ff) begin
                span_sel  = {8'h00, span_well};
                ticks_sel = hi_ticks;
            end else begin
                span_sel  = {8'h00, fmax_ff};
                ticks_sel = hi_ticks;
            end
        end
        if (span_sel == 24'h00_0000) begin
            span_sel = 24'h00_0001;
        end
        acc_sum = acc_ff + span_sel;
        step_q  = acc_sum / ticks_sel;
        nxt_acc = acc_sum - step_q * ticks_sel;
        if (ramp_freq == tgt) begin
            nxt_acc = 24'h00_0000;
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_ff <= 24'h00_0000;
        end else if (tick_ff) begin
            acc_ff <= nxt_acc;
        end
    end

    // drop from 30 Hz or below on stop is immediate under well protection
    wire zero_now = well_ff && (tgt == 16'h0000) && (freq_ref_ff <= `DIMRC_WELL_FREQ);

    dimrc_ramp u_ramp (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tick     (tick_ff),
        .coast    (coast_ff),
        .zero_now (zero_now),
        .target   (tgt),
        .up_step  (step_q[15:0]),
        .dn_step  (step_q[15:0]),
        .freq_ff  (ramp_freq)
    );

    // ------------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_ff           <= 1'b0;
            pressure_mode_ff <= 1'b0;
            sensor_sel_ff    <= 1'b0;
            setpoint_sel_ff  <= 1'b0;
            reg_unit_ff      <= 2'h0;
            precharge_en_ff  <= 1'b0;
            leadlag_en_ff    <= 1'b0;
            freq_ref_ff      <= 16'h0000;
        end else begin
            run_ff           <= run_req;
            pressure_mode_ff <= pmode && run_req;
            sensor_sel_ff    <= ssel;
            setpoint_sel_ff  <= spsel;
            reg_unit_ff      <= reg_unit_in;
            precharge_en_ff  <= is_pressure_cfg(cfg_ff);
            leadlag_en_ff    <= is_pressure_cfg(cfg_ff);
            freq_ref_ff      <= ramp_freq;
        end
    end

endmodule // dimrc_ctrl

// *** rtl/dimrc_defines.vh ***
// Purpose: constants for the drive input mode and ramp control block
// Assumes: 10 MHz core clock, frequencies in 0.1 Hz units, 12-bit analog codes
// Notes:   times are kept in their own units, cycle counts derived from them
`ifndef DIMRC_DEFINES_VH
`define DIMRC_DEFINES_VH

// ----------------------------------------------------------------------------
// configuration codes
// ----------------------------------------------------------------------------
`define DIMRC_CFG_BASIC      4'h0
`define DIMRC_CFG_DCP        4'h1
`define DIMRC_CFG_ACP        4'h2
`define DIMRC_CFG_RED        4'h3
`define DIMRC_CFG_DUAL       4'h4
`define DIMRC_CFG_VSPD       4'h5
`define DIMRC_CFG_ISPD       4'h6
`define DIMRC_CFG_HANDAUTO   4'h7

// ----------------------------------------------------------------------------
// frequency values, 0.1 Hz per lsb
// ----------------------------------------------------------------------------
`define DIMRC_FMIN_RST       16'h012C
`define DIMRC_FMIN_LOW       16'h0032
`define DIMRC_FMAX_RST       16'h0258
`define DIMRC_WELL_FREQ      16'h012C

// ----------------------------------------------------------------------------
// analog scaling
// ----------------------------------------------------------------------------
`define DIMRC_ADC_FULL       12'hFFF
`define DIMRC_ADC_4MA        12'h0333

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define DIMRC_CLK_HZ         10000000
`define DIMRC_TICK_US        1000
`define DIMRC_TICK_CYC       ((`DIMRC_CLK_HZ / 1000000) * `DIMRC_TICK_US)
`define DIMRC_UP_RAMP_S      8
`define DIMRC_UP_RAMP_RST    8'h08
`define DIMRC_WELL_S         1
`define DIMRC_TICKS_PER_S    (1000000 / `DIMRC_TICK_US)
`define DIMRC_WELL_TICKS     (`DIMRC_WELL_S * `DIMRC_TICKS_PER_S)
`define DIMRC_DN_RAMP_RST    8'h08
`define DIMRC_WELL_RST       1'b1
`define DIMRC_COAST_RST      1'b1
// sized forms of the derived counts
`define DIMRC_TICK_LAST      14'h270F
`define DIMRC_TPS_W          16'h03E8
`define DIMRC_WELL_TICKS_W   16'h03E8

`endif

// *** rtl/dimrc_ramp.v ***
// Purpose: frequency reference ramp generator with one-per-tick stepping
// Assumes: tick is a one-cycle enable; step sizes computed by the caller
// Notes:   the reference never overshoots the target
`timescale 1ns/1ps

module dimrc_ramp (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // control
    input  wire        tick,
    input  wire        coast,
    input  wire        zero_now,
    input  wire [15:0] target,
    input  wire [15:0] up_step,
    input  wire [15:0] dn_step,
    // result
    output reg  [15:0] freq_ff
);

    reg [15:0] nxt_freq;
    reg [16:0] sum;

    always @* begin
        sum      = {1'b0, freq_ff} + {1'b0, up_step};
        nxt_freq = freq_ff;
        if (zero_now || (coast && target == 16'h0000)) begin
            nxt_freq = 16'h0000;
        end else if (tick && freq_ff < target) begin
            // step up, clamp at target
            nxt_freq = (sum[15:0] > target || sum[16]) ? target : sum[15:0];
        end else if (tick && freq_ff > target) begin
            nxt_freq = (freq_ff - target < dn_step) ? target : freq_ff - dn_step;
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            freq_ff <= 16'h0000;
        end else begin
            freq_ff <= nxt_freq;
        end
    end

endmodule // dimrc_ramp

// *** test/dimrc_ctrl_checker.sv ***
// Purpose: concurrent checks on the mode decode and ramp outputs
// Assumes: parameters are shadowed here from the load strobe
// Notes:   decode checks hold off for two cycles after any parameter load; ramp checks do not
`timescale 1ns/1ps
`include "dimrc_defines.vh"

module dimrc_ctrl_checker (
    // clock and reset
    input wire        core_clk,
    input wire        rst_b,
    // inputs watched
    input wire        run_stop_contact,
    input wire        second_contact_input,
    input wire        mode_select_contact,
    input wire        param_load,
    input wire [3:0]  cfg_in,
    input wire        freewheel_stop_option,
    // outputs watched
    input wire        run_ff,
    input wire        pressure_mode_ff,
    input wire        sensor_sel_ff,
    input wire        setpoint_sel_ff,
    input wire        precharge_en_ff,
    input wire        leadlag_en_ff,
    input wire [15:0] freq_ref_ff
);
    reg  [3:0] cfg_sh_ff;
    reg        coast_sh_ff;
    reg        load_q_ff;
    wire       quiet     = !param_load && !load_q_ff;
    wire       spd       = cfg_sh_ff == `DIMRC_CFG_VSPD || cfg_sh_ff == `DIMRC_CFG_ISPD;
    wire       hand_auto = cfg_sh_ff == `DIMRC_CFG_HANDAUTO;
    wire       press_cfg = cfg_sh_ff inside {`DIMRC_CFG_DCP, `DIMRC_CFG_ACP, `DIMRC_CFG_RED,
                                             `DIMRC_CFG_DUAL, `DIMRC_CFG_HANDAUTO};

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_sh_ff   <= `DIMRC_CFG_BASIC;
            coast_sh_ff <= `DIMRC_COAST_RST;
            load_q_ff   <= 1'b0;
        end else begin
            load_q_ff <= param_load;
            if (param_load) begin
                cfg_sh_ff   <= cfg_in;
                coast_sh_ff <= freewheel_stop_option;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_basic_run: assert property (quiet && cfg_sh_ff == `DIMRC_CFG_BASIC
        |=> run_ff == ($past(run_stop_contact) && $past(second_contact_input)))
        else $error("basic mode run does not follow both contacts");
    chk_dual_run: assert property (quiet && cfg_sh_ff == `DIMRC_CFG_DUAL
        |=> run_ff == $past(run_stop_contact))
        else $error("dual sensor run does not follow run contact");
    chk_dual_sel: assert property (quiet && cfg_sh_ff == `DIMRC_CFG_DUAL
        && run_stop_contact
        |=> sensor_sel_ff == $past(second_contact_input) && setpoint_sel_ff == sensor_sel_ff)
        else $error("dual sensor selection wrong");
    chk_spd_gate: assert property (quiet && spd
        && !(run_stop_contact && second_contact_input)
        |=> !run_ff && !pressure_mode_ff)
        else $error("speed mode runs without both contacts");
    chk_sel_off: assert property (quiet && hand_auto && !run_stop_contact |=> !run_ff)
        else $error("off position still runs");
    chk_sel_auto: assert property (quiet && hand_auto && run_stop_contact
        && !mode_select_contact
        |=> run_ff == $past(second_contact_input) && pressure_mode_ff == run_ff)
        else $error("auto position decode wrong");
    chk_pre_cfg: assert property (quiet
        |=> precharge_en_ff == press_cfg && leadlag_en_ff == precharge_en_ff)
        else $error("pump functions enabled outside pressure modes");
    chk_coast_zero: assert property ($fell(run_ff) && coast_sh_ff
        |-> ##[0:5] freq_ref_ff == 16'h0000)
        else $error("freewheel stop did not clear reference");
    chk_ramp_pace: assert property (run_ff && $changed(freq_ref_ff)
        |=> (!run_ff || $stable(freq_ref_ff)) [*8])
        else $error("reference moved twice within a tick");
endmodule // dimrc_ctrl_checker

bind dimrc_ctrl dimrc_ctrl_checker i_chk (
    .core_clk(core_clk), .rst_b(rst_b), .run_stop_contact(run_stop_contact),
    .second_contact_input(second_contact_input), .mode_select_contact(mode_select_contact),
    .param_load(param_load), .cfg_in(cfg_in), .freewheel_stop_option(freewheel_stop_option),
    .run_ff(run_ff), .pressure_mode_ff(pressure_mode_ff), .sensor_sel_ff(sensor_sel_ff),
    .setpoint_sel_ff(setpoint_sel_ff), .precharge_en_ff(precharge_en_ff),
    .leadlag_en_ff(leadlag_en_ff), .freq_ref_ff(freq_ref_ff)
);

// *** test/dimrc_field_model.sv ***
// Purpose: field side model: contact switches, transducers, potentiometer
// Assumes: the bench sets the wanted field state once a cycle at most
// Notes:   dry contacts read high when closed; one cycle of wiring delay
`timescale 1ns/1ps

module dimrc_field_model (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // wanted field state
    input  wire [2:0]  want_contacts,
    input  wire [11:0] want_level,
    // towards the drive
    output reg         run_stop_contact,
    output reg         second_contact_input,
    output reg         mode_select_contact,
    output reg  [11:0] primary_loop_input,
    output reg  [11:0] volt_input,
    output wire [11:0] secondary_loop_input,
    output wire [15:0] pressure_freq
);
    assign secondary_loop_input = ~primary_loop_input;
    assign pressure_freq        = 16'h0190;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_stop_contact     <= 1'b0;
            second_contact_input <= 1'b0;
            mode_select_contact  <= 1'b0;
            primary_loop_input   <= 12'h333;
            volt_input           <= 12'h000;
        end else begin
            run_stop_contact     <= want_contacts[2];
            second_contact_input <= want_contacts[1];
            mode_select_contact  <= want_contacts[0];
            primary_loop_input   <= want_level;
            volt_input           <= want_level;
        end
    end
endmodule // dimrc_field_model

// *** test/testbench.sv ***
// Purpose: self-checking bench for mode decode and start/stop ramps
// Assumes: 10 MHz clock, field state set through the field model
// Notes:   ramp steps measured across one 1 ms tick
`timescale 1ns/1ps

module testbench;
    reg         core_clk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [2:0]  want_contacts = 3'h0;
    reg  [11:0] want_level = 12'h333;
    reg         param_load = 1'b0;
    reg  [3:0]  cfg_in = 4'h0;
    reg  [15:0] floor_in = 16'h012C, max_in = 16'h0258;
    reg  [7:0]  ramp_in = 8'h08;
    reg         well_in = 1'b1, coast_in = 1'b1, pc;
    reg  [1:0]  unit_in = 2'h0;
    wire        rs, sc, ms, run_ff, pm, ss, sp, pre, ll;
    wire [11:0] prim, sec, volt;
    wire [15:0] pfreq, fref;
    wire [1:0]  unit_out;
    wire [5:0]  dec_bits = {run_ff, pm, ss, sp, pre, ll};
    integer     err_count = 0, total_checks = 0, cyc = 0, i;

    dimrc_field_model i_field (.core_clk(core_clk), .rst_b(rst_b), .want_contacts(want_contacts),
        .want_level(want_level), .run_stop_contact(rs), .second_contact_input(sc),
        .mode_select_contact(ms), .primary_loop_input(prim), .volt_input(volt),
        .secondary_loop_input(sec), .pressure_freq(pfreq));
    dimrc_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b), .run_stop_contact(rs),
        .second_contact_input(sc), .mode_select_contact(ms), .primary_loop_input(prim),
        .secondary_loop_input(sec), .volt_input(volt), .param_load(param_load), .cfg_in(cfg_in),
        .floor_freq_in(floor_in), .max_freq_in(max_in), .up_ramp_s_in(ramp_in),
        .dn_ramp_s_in(ramp_in), .well_protect_in(well_in), .freewheel_stop_option(coast_in),
        .reg_unit_in(unit_in), .pressure_freq(pfreq), .run_ff(run_ff), .pressure_mode_ff(pm),
        .sensor_sel_ff(ss), .setpoint_sel_ff(sp), .reg_unit_ff(unit_out),
        .precharge_en_ff(pre), .leadlag_en_ff(ll), .freq_ref_ff(fref));

    always #50 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            err_count = err_count + 1;
            close_out;
        end
    end

    task check(input string what, input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task close_out;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task set_p(input [3:0] c, input [15:0] fl, mx, input [7:0] rt, input wl, cs);
        begin
            @(posedge core_clk);
            param_load <= 1'b1;
            cfg_in     <= c;
            floor_in   <= fl;
            max_in     <= mx;
            ramp_in    <= rt;
            well_in    <= wl;
            coast_in   <= cs;
            unit_in    <= c[1:0];
            @(posedge core_clk);
            param_load <= 1'b0;
        end
    endtask

    task drive(input [2:0] k, input [11:0] a);
        begin
            @(posedge core_clk);
            want_contacts <= k;
            want_level    <= a;
            repeat (8) @(posedge core_clk);
            #1;
        end
    endtask

    task dec(input [3:0] c, input [15:0] fl, input [2:0] k, input [11:0] a, input [5:0] e);
        begin
            set_p(c, fl, 16'h0258, 8'h08, 1'b1, 1'b1);
            drive(k, a);
            check("decode", {10'h000, dec_bits}, {10'h000, e});
        end
    endtask

    task ramp(input [15:0] delta);
        reg [15:0] v;
        integer    n;
        begin
            v = fref;
            n = 0;
            while (fref === v && n < 12000) begin
                @(posedge core_clk);
                #1;
                n = n + 1;
            end
            v = fref;
            repeat (10000) @(posedge core_clk);
            #1;
            check("ramp step", fref, v + delta);
        end
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        dec(4'h0, 16'h012C, 3'h6, 12'hFFF, 6'h20);
        dec(4'h0, 16'h012C, 3'h4, 12'hFFF, 6'h00);
        dec(4'h4, 16'h012C, 3'h4, 12'hFFF, 6'h33);
        check("unit", {14'h0000, unit_out}, 16'h0000);
        dec(4'h4, 16'h012C, 3'h6, 12'hFFF, 6'h3F);
        dec(4'h4, 16'h012C, 3'h0, 12'hFFF, 6'h03);
        dec(4'h5, 16'h012C, 3'h6, 12'hFFF, 6'h20);
        dec(4'h5, 16'h012C, 3'h6, 12'h000, 6'h00);
        dec(4'h5, 16'h012C, 3'h4, 12'hFFF, 6'h00);
        dec(4'h6, 16'h012C, 3'h6, 12'hFFF, 6'h20);
        dec(4'h6, 16'h012C, 3'h6, 12'h333, 6'h00);
        dec(4'h6, 16'h012C, 3'h2, 12'hFFF, 6'h00);
        dec(4'h7, 16'h012C, 3'h6, 12'hFFF, 6'h33);
        check("unit", {14'h0000, unit_out}, 16'h0003);
        dec(4'h7, 16'h012C, 3'h4, 12'hFFF, 6'h03);
        dec(4'h7, 16'h012C, 3'h5, 12'hFFF, 6'h23);
        dec(4'h7, 16'h012C, 3'h3, 12'hFFF, 6'h03);
        $display("test decode done");
        dec(4'h5, 16'h012C, 3'h6, 12'h200, 6'h00);
        dec(4'h5, 16'h0032, 3'h6, 12'h200, 6'h20);
        dec(4'h5, 16'h000A, 3'h6, 12'h060, 6'h00);
        for (i = 0; i < 8; i = i + 1) begin
            pc = (i == 1 || i == 2 || i == 3 || i == 4 || i == 7);
            dec(i[3:0], 16'h012C, 3'h0, 12'h000, {4'h0, pc, pc});
        end
        $display("test floor and pump functions done");
        set_p(4'h0, 16'h0BB8, 16'h1770, 8'h03, 1'b1, 1'b1);
        drive(3'h6, 12'h000);
        ramp(16'h0003);
        drive(3'h0, 12'h000);
        check("coast", fref, 16'h0000);
        set_p(4'h0, 16'h0BB8, 16'h1770, 8'h03, 1'b0, 1'b0);
        drive(3'h6, 12'h000);
        ramp(16'h0002);
        drive(3'h0, 12'h000);
        ramp(16'hFFFF);
        $display("test ramps done");
        close_out;
    end
endmodule // testbench
